// ---- design/ehc_pkg.sv ----
// Constants, state encoding and register layout for the encoder register bank
// Behaviour
// R1: Master forces extended mode before changing format
// R2: Plain mode shifts 13-bit Gray position, zero padded
// R3: Bytes 0x00-0x0F drive the live hardware settings
// R4: Bytes 0x10-0x1F read back fuse contents only
// R5: Fuses load into settings after reset, lock blocks
// R6: Unlocked: settings and 0x78-0x7F writable, rest read-only
// R7: Locked: only 0x7B/0x7C writable, 0x77-0x7F readable
// R8: Error pin low on error, released after 1 ms
// R9: Pull-up bit 0x04[6]: zero enables the pull-up
// R10: Profile address 0x42 always reads 0x2C; reads zero here while locked
// R11: Frame before position valid sets unready flag
// R12: Separate flags for amplitude high and low
// R13: Pin pulled low externally sets external flag
// R14: Status read clears flags and frame error bit
// R15: Timeout 16 us, or 2 us if either bit set
// R16: Volatile short timeout resets, fuse bit is permanent
// R17: Bytes 0x7D-0x7F hold a module identification value
// R18: Bit 0x0F[7] selects high current fuse reading
// R19: Start bit programs fuses; needs voltage, zero test
// R20: Programming ends with success or failure flag
// R21: Extended mode when voltage applied or select bit zero
// R22: Protected accesses change nothing, protected reads give zero
package ehc_pkg;

  // ----------------------------------------------------------------
  // Timing
  // ----------------------------------------------------------------
  localparam int CLK_MHZ      = 50;
  localparam int TO_LONG_US   = 16;
  localparam int TO_SHORT_US  = 2;
  localparam int TO_LONG_CYC  = TO_LONG_US * CLK_MHZ;
  localparam int TO_SHORT_CYC = TO_SHORT_US * CLK_MHZ;
  localparam int RELEASE_MS   = 1;
  localparam int RELEASE_CYC  = RELEASE_MS * 1000 * CLK_MHZ;
  localparam int TO_W         = 10;

  // ----------------------------------------------------------------
  // Address map
  // ----------------------------------------------------------------
  localparam logic [6:0] A_CFG_LAST   = 7'h0F;
  localparam logic [6:0] A_FUSE_LAST  = 7'h1F;
  localparam logic [6:0] A_PROFILE    = 7'h42;
  localparam logic [6:0] A_STATUS     = 7'h77;
  localparam logic [6:0] A_OEM_FIRST  = 7'h78;
  localparam logic [6:0] A_OPEN_FIRST = 7'h7B;
  localparam logic [6:0] A_OPEN_LAST  = 7'h7C;
  localparam logic [7:0] DATA_FORMAT_PROFILE   = 8'h2C;

  // ----------------------------------------------------------------
  // Fields inside the settings bytes
  // ----------------------------------------------------------------
  localparam int IDX_ERRPIN  = 4;
  localparam int IDX_OUTLOCK = 5;
  localparam int IDX_TIMEOUT = 14;
  localparam int IDX_TEST    = 15;
  localparam int B_PULL_DIS  = 6;
  localparam int B_LOCK      = 6;
  localparam int B_SSI_SEL   = 7;
  localparam int B_TO_PERM   = 0;
  localparam int B_TO_VOL    = 1;
  localparam int B_HC_READ   = 7;
  localparam int B_PROG      = 6;
  localparam int TEST_MSB    = 2;
  localparam int TEST_LSB    = 0;

  // ----------------------------------------------------------------
  // Status flags
  // ----------------------------------------------------------------
  localparam int NFLAGS = 6;
  localparam int S_FAIL = 0;
  localparam int S_OK   = 1;
  localparam int S_UNRDY = 2;
  localparam int S_AHI  = 3;
  localparam int S_ALO  = 4;
  localparam int S_EXT  = 5;
  localparam logic [NFLAGS-1:0] ERR_MASK = 6'h1D;

  // ----------------------------------------------------------------
  // Serial frame
  // ----------------------------------------------------------------
  localparam logic [4:0] F_ADDR_END = 5'h08;
  localparam logic [4:0] F_END      = 5'h10;

  typedef enum logic [1:0] {
    ST_LOAD = 2'h0,
    ST_IDLE = 2'h1,
    ST_PROG = 2'h3
  } ehc_state_e;

endpackage

// ---- design/ehc_regs.sv ----
// Register bank, fuse model, serial access and error pin of the encoder
`timescale 1ns/1ps
module ehc_regs #(
  parameter int         RELEASE_CYC = ehc_pkg::RELEASE_CYC,
  parameter int         PROG_CYCLES = 64,
  parameter logic [7:0] OEM_ID0     = 8'hA5, // Arbitrary value
  parameter logic [7:0] OEM_ID1     = 8'h5A, // Arbitrary value
  parameter logic [7:0] OEM_ID2     = 8'h3C  // Arbitrary value
) (
  // Clock and reset
  input  wire logic          clk_sys,
  input  wire logic          rst,
  // Serial interface pins
  input  wire logic          serial_clock_in,
  input  wire logic          serial_data_in,
  output logic               serial_data_out,
  // Programming voltage comparator pin
  input  wire logic          fuse_prog_voltage_pin,
  // Sensor front end
  input  wire logic [11:0]   position,
  input  wire logic          position_valid,
  input  wire logic          amp_high,
  input  wire logic          amp_low,
  // Open-drain error pin
  input  wire logic          error_pin_n_in,
  output logic               error_pin_n_out,
  output logic               error_pin_n_oe,
  output logic               error_pullup_en,
  // Settings and state to the rest of the chip
  output logic [127:0]       cfg_live,
  output logic               ssi_plain_mode,
  output logic               frame_error_bit_n,
  output logic               fuse_high_current_read,
  output logic               prog_busy
);

  localparam int RW = $clog2(RELEASE_CYC + 1);
  localparam int PW = $clog2(PROG_CYCLES + 1);

  typedef struct packed {
    ehc_pkg::ehc_state_e       st;
    logic [15:0][7:0]          cfg;
    logic                      busy;
    logic [7:0][7:0]           oem;
    logic [ehc_pkg::NFLAGS-1:0] flags;
    logic                      ma_s1;
    logic                      ma_s2;
    logic                      ma_p;
    logic                      sli_s1;
    logic                      sli_s2;
    logic                      vz_s1;
    logic                      vz_s2;
    logic                      ep_s1;
    logic                      ep_s2;
    logic                      in_frame;
    logic                      fplain;
    logic                      plain;
    logic                      rd;
    logic [4:0]                bitcnt;
    logic [15:0]               sh;
    logic [15:0]               osh;
    logic [ehc_pkg::TO_W-1:0]  to_cnt;
    logic [PW-1:0]             prog_cnt;
    logic [RW-1:0]             rel_cnt;
    logic [2:0]                oe_h;
    logic                      slo;
    logic                      oe;
    logic                      pull_en;
    logic                      hc;
    logic                      ferr_n;
  } ehc_state_s;

  ehc_state_s q;
  ehc_state_s d;

  // Fuse cells keep their contents through rst; blank cells read zero
  logic [15:0][7:0] fuse_r = '0;
  logic [15:0][7:0] fuse_nxt;

  // ----------------------------------------------------------------
  // Access decoding
  // ----------------------------------------------------------------
  function automatic logic writable(input logic [6:0] a, input logic lock);
    if (lock) begin
      writable = (a >= ehc_pkg::A_OPEN_FIRST) && (a <= ehc_pkg::A_OPEN_LAST); // R7
    end else begin
      writable = (a <= ehc_pkg::A_CFG_LAST) || (a >= ehc_pkg::A_OEM_FIRST); // R6
    end
  endfunction

  function automatic logic [7:0] rd_byte(input ehc_state_s s, input logic [15:0][7:0] fz,
                                         input logic [6:0] a);
    logic lock;
    lock = s.cfg[ehc_pkg::IDX_OUTLOCK][ehc_pkg::B_LOCK];
    rd_byte = 8'h00;
    if (lock && a < ehc_pkg::A_STATUS) begin
      rd_byte = 8'h00; // R7 R22
    end else if (a <= ehc_pkg::A_CFG_LAST) begin
      rd_byte = s.cfg[a[3:0]]; // R3
    end else if (a <= ehc_pkg::A_FUSE_LAST) begin
      rd_byte = fz[a[3:0]]; // R4
    end else if (a == ehc_pkg::A_PROFILE) begin
      rd_byte = ehc_pkg::DATA_FORMAT_PROFILE; // R10
    end else if (a == ehc_pkg::A_STATUS) begin
      rd_byte = 8'(s.flags);
    end else if (a >= ehc_pkg::A_OEM_FIRST) begin
      rd_byte = s.oem[a[2:0]]; // R17
    end
  endfunction

  function automatic logic [12:0] gray13(input logic [11:0] p);
    gray13 = {p ^ (p >> 1), 1'b0}; // R2
  endfunction

  // ----------------------------------------------------------------
  // Next state
  // ----------------------------------------------------------------
  always_comb begin
    logic                      rise;
    logic                      fall;
    logic                      lock;
    logic                      err_any;
    logic [6:0]                addr;
    logic [7:0]                rdat;
    logic [ehc_pkg::TO_W-1:0]  to_lim;
    logic [ehc_pkg::NFLAGS-1:0] set;
    logic [ehc_pkg::NFLAGS-1:0] clr;
    to_lim = ehc_pkg::TO_W'(ehc_pkg::TO_LONG_CYC - 1); // R15
    rise = q.ma_s2 & ~q.ma_p;
    fall = ~q.ma_s2 & q.ma_p;
    lock = q.cfg[ehc_pkg::IDX_OUTLOCK][ehc_pkg::B_LOCK];
    err_any = |(q.flags & ehc_pkg::ERR_MASK) | amp_high | amp_low;
    addr = 7'h00;
    rdat = 8'h00;
    set = '0;
    clr = '0;
    fuse_nxt = fuse_r;
    if (q.cfg[ehc_pkg::IDX_TIMEOUT][ehc_pkg::B_TO_VOL] ||
        fuse_r[ehc_pkg::IDX_TIMEOUT][ehc_pkg::B_TO_PERM]) begin
      to_lim = ehc_pkg::TO_W'(ehc_pkg::TO_SHORT_CYC - 1); // R15 R16
    end
    d = q;

    // Pin synchronisers
    d.ma_s1 = serial_clock_in;
    d.ma_s2 = q.ma_s1;
    d.ma_p = q.ma_s2;
    d.sli_s1 = serial_data_in;
    d.sli_s2 = q.sli_s1;
    d.vz_s1 = fuse_prog_voltage_pin;
    d.vz_s2 = q.vz_s1;
    d.ep_s1 = error_pin_n_in;
    d.ep_s2 = q.ep_s1;

    d.plain = ~q.vz_s2 & q.cfg[ehc_pkg::IDX_OUTLOCK][ehc_pkg::B_SSI_SEL]; // R21
    d.pull_en = ~q.cfg[ehc_pkg::IDX_ERRPIN][ehc_pkg::B_PULL_DIS]; // R9
    d.hc = q.cfg[ehc_pkg::IDX_TEST][ehc_pkg::B_HC_READ]; // R18

    // Fuse load and programming sequence
    case (q.st)
      ehc_pkg::ST_LOAD: begin
        d.cfg = fuse_r; // R5
        d.cfg[ehc_pkg::IDX_TIMEOUT][ehc_pkg::B_TO_VOL] = 1'b0; // R16
        d.st = ehc_pkg::ST_IDLE;
      end
      ehc_pkg::ST_IDLE: begin
        if (q.cfg[ehc_pkg::IDX_TEST][ehc_pkg::B_PROG]) begin
          d.st = ehc_pkg::ST_PROG; // R19
          d.prog_cnt = '0;
        end
      end
      ehc_pkg::ST_PROG: begin
        if (q.prog_cnt == PW'(PROG_CYCLES - 1)) begin
          d.cfg[ehc_pkg::IDX_TEST][ehc_pkg::B_PROG] = 1'b0; // R19
          if (q.vz_s2 && q.cfg[ehc_pkg::IDX_TEST][ehc_pkg::TEST_MSB:ehc_pkg::TEST_LSB] == '0) begin
            for (int i = 0; i < 16; i++) begin
              fuse_nxt[i] = fuse_r[i] | d.cfg[i]; // R19
            end
            set[ehc_pkg::S_OK] = 1'b1; // R20
          end else begin
            set[ehc_pkg::S_FAIL] = 1'b1; // R20
          end
          d.st = ehc_pkg::ST_IDLE;
        end else begin
          d.prog_cnt = q.prog_cnt + PW'(1);
        end
      end
      default: begin
        d.st = ehc_pkg::ST_LOAD;
      end
    endcase
    d.busy = (d.st == ehc_pkg::ST_PROG);

    // Serial frames
    if (!q.in_frame) begin
      d.slo = 1'b1;
      if (fall) begin
        d.in_frame = 1'b1;
        d.fplain = q.plain; // R1
        d.bitcnt = 5'h00;
        d.to_cnt = '0;
        d.rd = 1'b0;
        d.osh = {gray13(position), 3'h0}; // R2
        if (!position_valid) begin
          set[ehc_pkg::S_UNRDY] = 1'b1; // R11
        end
      end
    end else begin
      if (rise || fall) begin
        d.to_cnt = '0;
      end else if (q.ma_s2) begin
        if (q.to_cnt >= to_lim) begin
          d.in_frame = 1'b0; // R15
          d.slo = 1'b1;
        end else begin
          d.to_cnt = q.to_cnt + ehc_pkg::TO_W'(1);
        end
      end
      if (q.fplain) begin
        if (rise) begin
          d.slo = q.osh[15]; // R2
          d.osh = {q.osh[14:0], 1'b0};
        end
      end else begin
        if (rise && q.bitcnt != ehc_pkg::F_END) begin
          d.bitcnt = q.bitcnt + 5'h01;
          d.sh = {q.sh[14:0], q.sli_s2};
          if (q.bitcnt == ehc_pkg::F_ADDR_END - 5'h01 && q.sh[6]) begin
            addr = {q.sh[5:0], q.sli_s2};
            rdat = rd_byte(q, fuse_r, addr);
            d.rd = 1'b1;
            d.slo = rdat[7];
            d.osh = {rdat[6:0], 9'h000};
            if (addr == ehc_pkg::A_STATUS) begin
              clr = '1; // R14
            end
          end
          if (q.bitcnt == ehc_pkg::F_END - 5'h01 && !q.sh[14]) begin
            addr = q.sh[13:7];
            if (writable(addr, lock)) begin // R22
              if (addr <= ehc_pkg::A_CFG_LAST) begin
                d.cfg[addr[3:0]] = {q.sh[6:0], q.sli_s2}; // R3 R5
              end else begin
                d.oem[addr[2:0]] = {q.sh[6:0], q.sli_s2};
              end
            end
          end
        end
        if (fall && q.rd && q.bitcnt >= ehc_pkg::F_ADDR_END) begin
          d.slo = q.osh[15];
          d.osh = {q.osh[14:0], 1'b0};
        end
      end
    end

    // Error pin with release delay
    if (err_any) begin
      d.oe = 1'b1; // R8
      d.rel_cnt = RW'(RELEASE_CYC);
    end else if (q.oe) begin
      if (q.rel_cnt == '0) begin
        d.oe = 1'b0; // R8
      end else begin
        d.rel_cnt = q.rel_cnt - RW'(1);
      end
    end
    d.oe_h = {q.oe_h[1:0], q.oe};
    // Pin needs time to rise through the synchroniser after release
    if (!q.ep_s2 && !q.oe && q.oe_h == 3'h0) begin
      set[ehc_pkg::S_EXT] = 1'b1; // R13
    end
    set[ehc_pkg::S_AHI] = set[ehc_pkg::S_AHI] | amp_high; // R12
    set[ehc_pkg::S_ALO] = set[ehc_pkg::S_ALO] | amp_low; // R12

    // New events win over a clearing read
    d.flags = (q.flags & ~clr) | set; // R14
    d.ferr_n = ~|(d.flags & ehc_pkg::ERR_MASK); // R14
  end

  // ----------------------------------------------------------------
  // State register
  // ----------------------------------------------------------------
  always_ff @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      q <= '0;
      q.st <= ehc_pkg::ST_LOAD;
      q.oem[5] <= OEM_ID0; // R17
      q.oem[6] <= OEM_ID1;
      q.oem[7] <= OEM_ID2;
      q.ma_s1 <= 1'b1;
      q.ma_s2 <= 1'b1;
      q.ma_p <= 1'b1;
      q.ep_s1 <= 1'b1;
      q.ep_s2 <= 1'b1;
      q.slo <= 1'b1;
      q.pull_en <= 1'b1;
      q.ferr_n <= 1'b1;
    end else begin
      q <= d;
    end
  end

  // No reset: programmed fuses must outlive rst, else R16 could be undone
  always_ff @(posedge clk_sys) begin
    fuse_r <= fuse_nxt;
  end

  // ----------------------------------------------------------------
  // Outputs
  // ----------------------------------------------------------------
  assign serial_data_out = q.slo;
  // Open drain: only ever pulls low
  assign error_pin_n_out = 1'b0;
  assign error_pin_n_oe = q.oe;
  assign error_pullup_en = q.pull_en;
  assign cfg_live = q.cfg;
  assign ssi_plain_mode = q.plain;
  assign frame_error_bit_n = q.ferr_n;
  assign fuse_high_current_read = q.hc;
  assign prog_busy = q.busy;

endmodule

// ---- tb/ehc_regs_properties.sv ----
// Port checker for the encoder register bank
`timescale 1ns/1ps
module ehc_regs_properties #(
  parameter int RELEASE_CYC = 20,
  parameter int PROG_CYCLES = 4
) (
  // Clock and reset
  input wire logic         clk_sys,
  input wire logic         rst,
  // Serial pins
  input wire logic         serial_clock_in,
  input wire logic         serial_data_in,
  input wire logic         serial_data_out,
  input wire logic         fuse_prog_voltage_pin,
  // Front end
  input wire logic [11:0]  position,
  input wire logic         position_valid,
  input wire logic         amp_high,
  input wire logic         amp_low,
  // Error pin
  input wire logic         error_pin_n_in,
  input wire logic         error_pin_n_out,
  input wire logic         error_pin_n_oe,
  input wire logic         error_pullup_en,
  // State
  input wire logic [127:0] cfg_live,
  input wire logic         ssi_plain_mode,
  input wire logic         frame_error_bit_n,
  input wire logic         fuse_high_current_read,
  input wire logic         prog_busy
);
  logic [15:0] quiet_cnt, busy_cnt, high_cnt;

  // Cycles without error, in programming, with the link clock high
  always_ff @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      quiet_cnt <= 16'h0000;
      busy_cnt  <= 16'h0000;
      high_cnt  <= 16'h0000;
    end else begin
      quiet_cnt <= (amp_high || amp_low || !frame_error_bit_n) ? 16'h0000 : quiet_cnt + 16'h0001;
      busy_cnt  <= prog_busy ? busy_cnt + 16'h0001 : 16'h0000;
      high_cnt  <= serial_clock_in ? high_cnt + 16'h0001 : 16'h0000;
    end
  end

  default clocking @(posedge clk_sys); endclocking
  default disable iff (rst);

  pull_up_a: assert property (error_pullup_en == !$past(cfg_live[38]))
    else $error("pull-up enable does not follow its control bit");
  oe_amp_a: assert property ((amp_high || amp_low) |=> error_pin_n_oe)
    else $error("error pin not driven on amplitude error");
  oe_flag_a: assert property (!frame_error_bit_n [*2] |-> error_pin_n_oe)
    else $error("error pin not driven while a flag is set");
  release_early_a: assert property ($fell(error_pin_n_oe) |-> quiet_cnt >= RELEASE_CYC - 2)
    else $error("error pin released too early");
  release_late_a: assert property (quiet_cnt == RELEASE_CYC + 4 |-> !error_pin_n_oe)
    else $error("error pin released too late");
  ext_mode_a: assert property ((fuse_prog_voltage_pin || !cfg_live[47]) [*4] |-> !ssi_plain_mode)
    else $error("plain mode while extended mode is forced");
  plain_mode_a: assert property ((!fuse_prog_voltage_pin && cfg_live[47]) [*4] |-> ssi_plain_mode)
    else $error("plain mode not entered");
  prog_len_a: assert property ($fell(prog_busy) |-> busy_cnt inside {[PROG_CYCLES-1:PROG_CYCLES+1]})
    else $error("programming length wrong");
  idle_out_a: assert property (high_cnt == 16'h032A |-> serial_data_out)
    else $error("data output not idle after timeout");

  cover property ($rose(prog_busy));
  cover property ($fell(error_pin_n_oe));
  cover property ($rose(ssi_plain_mode));
endmodule

bind ehc_regs ehc_regs_properties #(.RELEASE_CYC(RELEASE_CYC), .PROG_CYCLES(PROG_CYCLES)) u_props (.*);

// ---- tb/ehc_master.sv ----
// Serial master model that clocks the encoder interface
`timescale 1ns/1ps
module ehc_master (
  // Serial pins
  output logic     link_clk,
  output logic     link_do,
  input wire logic link_di
);
  initial begin
    link_clk = 1'b1;
    link_do  = 1'b0;
  end

  // Bits change on falls; read data is taken just before the next fall
  task automatic xfer(input logic rw, input logic [6:0] a, input logic [7:0] d,
                      input int gap, output logic [15:0] cap);
    logic [15:0] w;
    w   = {rw, a, d};
    cap = 16'h0000;
    #7;
    for (int k = 0; k < 16; k++) begin
      link_clk = 1'b0;
      link_do  = w[15-k];
      #60;
      link_clk = 1'b1;
      #100;
      cap = {cap[14:0], link_di};
    end
    // Released line must not look like a held bit
    link_do = ~link_do;
    #(gap * 20);
  endtask
endmodule

// ---- tb/ehc_regs_bench.sv ----
// Self-checking bench for the encoder register bank
`timescale 1ns/1ps
module ehc_regs_bench;
  typedef struct packed {
    logic       rw;
    logic [6:0] addr;
    logic [7:0] data;
  } ehc_row_s;

  logic         clk_sys, rst, sclk, sdi, sdo, vz, pv, ahi, alo, ext_pull;
  logic         oe, pu, feb, plain, hc, busy;
  logic [11:0]  pos;
  logic [127:0] cfg;
  logic [15:0]  cap;
  int           fail_count, cmp_count, gap;
  wire          pin_n = !(oe || ext_pull);
  // Reads carry the expected data in the data column
  ehc_row_s rows [13] = '{'{1'b0, 7'h04, 8'h40}, '{1'b1, 7'h04, 8'h40}, '{1'b1, 7'h42, 8'h2C},
    '{1'b0, 7'h10, 8'hFF}, '{1'b1, 7'h10, 8'h00}, '{1'b0, 7'h78, 8'h33}, '{1'b1, 7'h78, 8'h33},
    '{1'b1, 7'h7D, 8'hA5}, '{1'b1, 7'h7E, 8'h5A}, '{1'b1, 7'h7F, 8'h3C}, '{1'b1, 7'h20, 8'h00},
    '{1'b0, 7'h77, 8'hFF}, '{1'b0, 7'h0E, 8'h02}};

  ehc_regs #(.RELEASE_CYC(20), .PROG_CYCLES(4), .OEM_ID0(8'hA5), .OEM_ID1(8'h5A),
    .OEM_ID2(8'h3C)) dut (
    .clk_sys(clk_sys), .rst(rst), .serial_clock_in(sclk), .serial_data_in(sdi),
    .serial_data_out(sdo), .fuse_prog_voltage_pin(vz), .position(pos),
    .position_valid(pv), .amp_high(ahi), .amp_low(alo), .error_pin_n_in(pin_n),
    .error_pin_n_out(), .error_pin_n_oe(oe), .error_pullup_en(pu), .cfg_live(cfg),
    .ssi_plain_mode(plain), .frame_error_bit_n(feb), .fuse_high_current_read(hc),
    .prog_busy(busy));
  ehc_master u_mst (.link_clk(sclk), .link_do(sdi), .link_di(sdo));

  initial begin
    clk_sys = 1'b0;
    forever #10 clk_sys = ~clk_sys;
  end

  task automatic chk(input string nm, input logic [15:0] seen, input logic [15:0] exp);
    cmp_count++;
    if (seen !== exp) begin
      fail_count++;
      $display("unexpected %s expected %h seen %h", nm, exp, seen);
    end
  endtask

  task automatic acc(input logic rw, input logic [6:0] a, input logic [7:0] d);
    @(negedge clk_sys);
    u_mst.xfer(rw, a, d, gap, cap);
    @(negedge clk_sys);
    if (rw) chk($sformatf("reg %h", a), {8'h00, cap[8:1]}, {8'h00, d});
  endtask

  task automatic summarize;
    $display("comparisons %0d mismatches %0d", cmp_count, fail_count);
    if (fail_count == 0 && cmp_count > 0) $display("Simulation passed");
    else $display("Simulation failed");
    $finish;
  endtask

  initial begin
    repeat (100000) @(posedge clk_sys);
    fail_count++;
    summarize();
  end

  initial begin
    rst = 1'b1; vz = 1'b0; pv = 1'b0; ahi = 1'b0; alo = 1'b0; ext_pull = 1'b0;
    pos = 12'h5A3; gap = 850; fail_count = 0; cmp_count = 0;
    repeat (2) @(negedge clk_sys);
    chk("reset outputs", {12'h000, sdo, oe, pu, feb}, 16'h000B);
    chk("reset settings", {15'h0000, |cfg}, 16'h0000);
    rst = 1'b0;
    repeat (2) @(negedge clk_sys);
    foreach (rows[i]) acc(rows[i].rw, rows[i].addr, rows[i].data);
    // Short timeout now set: a long one would merge the next frames
    gap = 150;
    pv = 1'b1;
    chk("pull-up", {15'h0000, pu}, 16'h0000);
    chk("frame error bit", {15'h0000, feb}, 16'h0000);
    acc(1'b1, 7'h77, 8'h04);
    chk("frame error bit", {15'h0000, feb}, 16'h0001);
    chk("error pin drive", {15'h0000, oe}, 16'h0000);
    for (int i = 0; i < 2; i++) begin
      ahi = (i == 0);
      alo = (i == 1);
      repeat (3) @(negedge clk_sys);
      chk("error pin drive", {15'h0000, oe}, 16'h0001);
      ahi = 1'b0;
      alo = 1'b0;
      acc(1'b1, 7'h77, 8'h08 << i);
    end
    ext_pull = 1'b1;
    repeat (8) @(negedge clk_sys);
    ext_pull = 1'b0;
    acc(1'b1, 7'h77, 8'h20);
    vz = 1'b1;
    acc(1'b0, 7'h05, 8'h80);
    vz = 1'b0;
    repeat (5) @(negedge clk_sys);
    chk("plain mode", {15'h0000, plain}, 16'h0001);
    acc(1'b0, 7'h00, 8'h00);
    chk("gray word", {3'h0, cap[15:3]}, {3'h0, pos ^ (pos >> 1), 1'b0});
    vz = 1'b1;
    repeat (5) @(negedge clk_sys);
    chk("plain mode", {15'h0000, plain}, 16'h0000);
    acc(1'b0, 7'h05, 8'h00);
    acc(1'b0, 7'h0F, 8'hC0);
    acc(1'b1, 7'h77, 8'h02);
    chk("start bit", {15'h0000, cfg[126]}, 16'h0000);
    chk("high current read", {15'h0000, hc}, 16'h0001);
    acc(1'b1, 7'h1F, 8'h80);
    acc(1'b1, 7'h14, 8'h40);
    acc(1'b0, 7'h0F, 8'h41);
    acc(1'b1, 7'h77, 8'h01);
    acc(1'b0, 7'h05, 8'h40);
    acc(1'b0, 7'h04, 8'h00);
    chk("locked setting", {8'h00, cfg[39:32]}, 16'h0040);
    acc(1'b1, 7'h04, 8'h00);
    acc(1'b1, 7'h42, 8'h00);
    acc(1'b0, 7'h7B, 8'h11);
    acc(1'b1, 7'h7B, 8'h11);
    acc(1'b0, 7'h78, 8'h44);
    acc(1'b1, 7'h78, 8'h33);
    rst = 1'b1;
    @(negedge clk_sys);
    rst = 1'b0;
    repeat (2) @(negedge clk_sys);
    gap = 850;
    chk("loaded setting", {8'h00, cfg[39:32]}, 16'h0040);
    chk("volatile timeout", {15'h0000, cfg[113]}, 16'h0000);
    acc(1'b1, 7'h04, 8'h40);
    summarize();
  end
endmodule
